// File: verilog/sme_pkg.sv
// Constants, opcodes, register map and types for the shift/move executor.
// Assumes an APB3 master with 32-bit data and a 12-bit byte address.
`default_nettype none

package sme_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;   // File register width
  localparam int unsigned PTR_W = 16;   // Indirect pointer width
  localparam int unsigned BANK_W = 5;   // Bank select width
  localparam int unsigned PAGE_W = 7;   // Program counter high latch width
  localparam int unsigned INSTR_W = 14; // Instruction word width
  localparam int unsigned FILE_W = 7;   // Direct file address width
  localparam int unsigned OFS_W = 6;    // Signed indirect offset width
  localparam int unsigned APB_AW = 12;  // APB byte address width

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_INSTR = 12'h000;  // Write: execute one instruction
  localparam logic [11:0] OFS_ACC = 12'h004;    // Working accumulator
  localparam logic [11:0] OFS_STATUS = 12'h008; // Carry, zero, unknown opcode
  localparam logic [11:0] OFS_BANK = 12'h00c;   // Bank select
  localparam logic [11:0] OFS_PAGE = 12'h010;   // Program counter high latch
  localparam logic [11:0] OFS_PTR [2] = '{12'h014, 12'h018}; // Indirect pointers
  localparam logic [11:0] OFS_DADDR = 12'h01c;  // Software data file address
  localparam logic [11:0] OFS_DATA = 12'h020;   // Software data file window

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_ZERO = 1;
  localparam int unsigned ST_UNK = 2;

  // ----------------------------------------------------------------
  // Opcodes, each matched on the top bits of the word
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_SHIFT = 6'h0d;     // Bits 13:8, d at 7, f at 6:0
  localparam logic [5:0] OPC_COPY = 6'h08;      // Bits 13:8, d at 7, f at 6:0
  localparam logic [5:0] OPC_ACC_LIT = 6'h30;   // Bits 13:8, literal 7:0
  localparam logic [6:0] OPC_IND_OFS = 7'h7e;   // Bits 13:7, n at 6, k 5:0
  localparam logic [6:0] OPC_PAGE_LIT = 7'h63;  // Bits 13:7, literal 6:0
  localparam logic [10:0] OPC_IND_MODE = 11'h002; // Bits 13:3, n at 2, mm 1:0
  localparam logic [8:0] OPC_BANK_LIT = 9'h001; // Bits 13:5, literal 4:0

  // Indirect mode field codes
  localparam logic [1:0] MM_PRE_INC = 2'b00;
  localparam logic [1:0] MM_PRE_DEC = 2'b01;
  localparam logic [1:0] MM_POST_INC = 2'b10;
  localparam logic [1:0] MM_POST_DEC = 2'b11;

  // Direct addresses that are windows onto the pointers
  localparam logic [6:0] WIN_ADDR [2] = '{7'h00, 7'h01};

  // Reset values and pointer step
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // Decoded instruction kinds
  typedef enum logic [2:0] {
    SME_OP_BAD, SME_OP_SHIFT, SME_OP_COPY, SME_OP_IND,
    SME_OP_BANK, SME_OP_PAGE, SME_OP_ACC, SME_OP_SWRD
  } sme_op_t;

  // Sequencer states
  typedef enum {SME_IDLE, SME_WAIT, SME_EXEC, SME_RESP} sme_state_t;

endpackage

`default_nettype wire

// File: verilog/sme_dfile_if.sv
// Port bundle between the executor and its data file memory.
// Assumes both ends share pclk; read data arrive one edge after re.
`timescale 1ns/1ps
`default_nettype none

interface sme_dfile_if #(
  parameter int unsigned ADDR_W = 9,
  parameter int unsigned DATA_W = 8
);
  logic [ADDR_W-1:0] addr;  // Word address
  logic re;                 // Read strobe
  logic we;                 // Write strobe
  logic [DATA_W-1:0] wdata; // Write data
  logic [DATA_W-1:0] rdata; // Registered read data

  // Executor side
  modport ctrl (output addr, output re, output we, output wdata, input rdata);
  // Memory side
  modport mem (input addr, input re, input we, input wdata, output rdata);
endinterface

`default_nettype wire

// File: verilog/sme_dfile.sv
// Data file memory: synchronous write, registered read.
// Assumes one clock; contents are not cleared by reset.
`timescale 1ns/1ps
`default_nettype none

module sme_dfile #(
  parameter int unsigned ADDR_W = 9,
  parameter int unsigned DATA_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  sme_dfile_if.mem port
);

  // Storage, left uninitialised to map onto plain RAM
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read port, output held between reads
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.rdata <= '0;
    end else if (port.re) begin
      port.rdata <= mem[port.addr];
    end
  end

endmodule

`default_nettype wire

// File: verilog/sme_exec.sv
// Shift/move instruction executor with an APB register front end.
// Assumes an APB3 master; one instruction is run per write to INSTR.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sme_exec #(
  parameter int unsigned ADDR_W = 9 // Data file address width, at most 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sme_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------
  logic [sme_pkg::DATA_W-1:0] acc;            // Working accumulator
  logic carry;                                // Carry flag
  logic zero;                                 // Zero flag
  logic unk;                                  // Last instruction not decoded
  logic [sme_pkg::BANK_W-1:0] bank_select;    // Bank select
  logic [sme_pkg::PAGE_W-1:0] program_counter_high_latch; // Page latch
  logic [sme_pkg::PTR_W-1:0] indirect_pointer [2]; // Indirect pointers
  logic [sme_pkg::PTR_W-1:0] sw_addr;         // Software data address

  // ----------------------------------------------------------------
  // Sequencer and captured instruction
  // ----------------------------------------------------------------
  sme_pkg::sme_state_t state;
  sme_pkg::sme_state_t next_state;
  sme_pkg::sme_op_t op_q;                     // Operation in flight
  logic dest_q;                               // Destination bit in flight

  // Data file port
  sme_dfile_if #(.ADDR_W(ADDR_W), .DATA_W(sme_pkg::DATA_W)) dfile ();

  sme_dfile #(
    .ADDR_W(ADDR_W),
    .DATA_W(sme_pkg::DATA_W)
  ) u_dfile (
    .pclk(pclk),
    .presetn(presetn),
    .port(dfile.mem)
  );

  // ----------------------------------------------------------------
  // Bus qualifiers
  // ----------------------------------------------------------------
  logic acc_start; // First access cycle seen while idle
  logic sw_wr;     // Software write accepted this cycle
  logic is_instr;  // Write to the instruction register
  logic is_data;   // Access to the data window
  logic hit;       // Address is mapped

  assign acc_start = (state == sme_pkg::SME_IDLE) && psel && penable && !pready;
  assign sw_wr = acc_start && pwrite;
  assign is_instr = pwrite && (paddr == sme_pkg::OFS_INSTR);
  assign is_data = (paddr == sme_pkg::OFS_DATA);

  // Every offset in the map answers, other offsets raise pslverr
  always_comb begin
    hit = 1'b0;
    case (paddr)
      sme_pkg::OFS_INSTR, sme_pkg::OFS_ACC, sme_pkg::OFS_STATUS,
      sme_pkg::OFS_BANK, sme_pkg::OFS_PAGE, sme_pkg::OFS_PTR[0],
      sme_pkg::OFS_PTR[1], sme_pkg::OFS_DADDR, sme_pkg::OFS_DATA: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Instruction decode from the write data
  // ----------------------------------------------------------------
  logic [sme_pkg::INSTR_W-1:0] iw;          // Instruction word
  sme_pkg::sme_op_t dec_op;                 // Decoded operation
  logic dec_dest;                           // Destination bit
  logic dec_sel;                            // Pointer index
  logic [sme_pkg::PTR_W-1:0] dec_addr;      // Operand address
  logic [sme_pkg::PTR_W-1:0] dec_ptr_next;  // Pointer after the load
  logic [sme_pkg::PTR_W-1:0] ptr_cur;       // Selected pointer
  logic [sme_pkg::PTR_W-1:0] ptr_inc;       // Selected pointer plus one
  logic [sme_pkg::PTR_W-1:0] ptr_dec;       // Selected pointer minus one
  logic [sme_pkg::PTR_W-1:0] ofs_ext;       // Sign-extended offset

  assign iw = pwdata[sme_pkg::INSTR_W-1:0];

  // Pointer index decoded apart from the opcode, so the pointer mux never loops back
  assign dec_sel = (iw[13:7] == sme_pkg::OPC_IND_OFS) ? iw[6] : iw[2];

  // Direct file address, window addresses replaced by the pointer value
  function automatic logic [sme_pkg::PTR_W-1:0] direct_addr(
    input logic [sme_pkg::FILE_W-1:0] f,
    input logic [sme_pkg::BANK_W-1:0] bk,
    input logic [sme_pkg::PTR_W-1:0] p0,
    input logic [sme_pkg::PTR_W-1:0] p1
  );
    logic [sme_pkg::PTR_W-1:0] a;
    a = {4'h0, bk, f};
    if (f == sme_pkg::WIN_ADDR[0]) begin
      a = p0;
    end else if (f == sme_pkg::WIN_ADDR[1]) begin
      a = p1;
    end
    return a;
  endfunction

  // Pointer arithmetic wraps in sixteen bits on its own
  assign ptr_cur = indirect_pointer[dec_sel];
  assign ptr_inc = ptr_cur + sme_pkg::PTR_STEP;
  assign ptr_dec = ptr_cur - sme_pkg::PTR_STEP;
  assign ofs_ext = {{(sme_pkg::PTR_W - sme_pkg::OFS_W){iw[sme_pkg::OFS_W-1]}}, iw[sme_pkg::OFS_W-1:0]};

  // Opcodes are disjoint, so the order of tests is free
  always_comb begin
    dec_op = sme_pkg::SME_OP_BAD;
    dec_dest = iw[7];
    dec_addr = direct_addr(iw[6:0], bank_select, indirect_pointer[0], indirect_pointer[1]);
    dec_ptr_next = ptr_cur;
    if (iw[13:8] == sme_pkg::OPC_SHIFT) begin
      dec_op = sme_pkg::SME_OP_SHIFT;
    end else if (iw[13:8] == sme_pkg::OPC_COPY) begin
      dec_op = sme_pkg::SME_OP_COPY;
    end else if (iw[13:8] == sme_pkg::OPC_ACC_LIT) begin
      dec_op = sme_pkg::SME_OP_ACC;
    end else if (iw[13:7] == sme_pkg::OPC_IND_OFS) begin
      // Offset mode: pointer plus k, pointer left alone
      dec_op = sme_pkg::SME_OP_IND;
      dec_addr = ptr_cur + ofs_ext;
      dec_ptr_next = ptr_cur;
    end else if (iw[13:7] == sme_pkg::OPC_PAGE_LIT) begin
      dec_op = sme_pkg::SME_OP_PAGE;
    end else if (iw[13:3] == sme_pkg::OPC_IND_MODE) begin
      dec_op = sme_pkg::SME_OP_IND;
      case (iw[1:0])
        sme_pkg::MM_PRE_INC: begin
          dec_addr = ptr_inc;
          dec_ptr_next = ptr_inc;
        end
        sme_pkg::MM_PRE_DEC: begin
          dec_addr = ptr_dec;
          dec_ptr_next = ptr_dec;
        end
        sme_pkg::MM_POST_INC: begin
          dec_addr = ptr_cur;
          dec_ptr_next = ptr_inc;
        end
        default: begin
          dec_addr = ptr_cur;
          dec_ptr_next = ptr_dec;
        end
      endcase
    end else if (iw[13:5] == sme_pkg::OPC_BANK_LIT) begin
      dec_op = sme_pkg::SME_OP_BANK;
    end
  end

  // Operations that must read the data file first
  logic dec_needs_mem;
  assign dec_needs_mem = (dec_op == sme_pkg::SME_OP_SHIFT) || (dec_op == sme_pkg::SME_OP_COPY) ||
                         (dec_op == sme_pkg::SME_OP_IND);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Accesses that read the data file take three cycles, the rest take one
  always_comb begin
    next_state = state;
    case (state)
      sme_pkg::SME_IDLE: begin
        if (acc_start) begin
          if (is_instr && dec_needs_mem) begin
            next_state = sme_pkg::SME_WAIT;
          end else if (is_data && !pwrite) begin
            next_state = sme_pkg::SME_WAIT;
          end else begin
            next_state = sme_pkg::SME_RESP;
          end
        end
      end
      sme_pkg::SME_WAIT: begin
        next_state = sme_pkg::SME_EXEC;
      end
      sme_pkg::SME_EXEC: begin
        next_state = sme_pkg::SME_RESP;
      end
      sme_pkg::SME_RESP: begin
        next_state = sme_pkg::SME_IDLE;
      end
      default: begin
        next_state = sme_pkg::SME_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sme_pkg::SME_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture what the execute cycle needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= sme_pkg::SME_OP_BAD;
      dest_q <= 1'b0;
    end else if (acc_start) begin
      op_q <= is_instr ? dec_op : sme_pkg::SME_OP_SWRD;
      dest_q <= dec_dest;
    end
  end

  // ----------------------------------------------------------------
  // Execute-cycle results
  // ----------------------------------------------------------------
  logic exec_fire;                          // Memory data valid this cycle
  logic [sme_pkg::DATA_W-1:0] shift_res;    // Right shift result

  assign exec_fire = (state == sme_pkg::SME_EXEC);
  assign shift_res = {1'b0, dfile.rdata[sme_pkg::DATA_W-1:1]};

  // ----------------------------------------------------------------
  // Data file port
  // ----------------------------------------------------------------
  // Write-back reuses the read address, so the window redirect holds for both
  logic [sme_pkg::PTR_W-1:0] opnd_q; // Operand address in flight

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_q <= '0;
      dfile.addr <= '0;
      dfile.re <= 1'b0;
      dfile.we <= 1'b0;
      dfile.wdata <= '0;
    end else begin
      dfile.re <= 1'b0;
      dfile.we <= 1'b0;
      if (acc_start && is_instr && dec_needs_mem) begin
        opnd_q <= dec_addr;
        dfile.addr <= dec_addr[ADDR_W-1:0];
        dfile.re <= 1'b1;
      end else if (acc_start && is_data) begin
        dfile.addr <= sw_addr[ADDR_W-1:0];
        dfile.re <= !pwrite;
        dfile.we <= pwrite;
        dfile.wdata <= pwdata[sme_pkg::DATA_W-1:0];
      end else if (exec_fire && dest_q) begin
        if (op_q == sme_pkg::SME_OP_SHIFT) begin
          dfile.addr <= opnd_q[ADDR_W-1:0];
          dfile.we <= 1'b1;
          dfile.wdata <= shift_res;
        end else if (op_q == sme_pkg::SME_OP_COPY) begin
          dfile.addr <= opnd_q[ADDR_W-1:0];
          dfile.we <= 1'b1;
          dfile.wdata <= dfile.rdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  // Software and instructions never touch these in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= sme_pkg::RST_ACC;
      carry <= 1'b0;
      zero <= 1'b0;
      unk <= 1'b0;
    end else if (sw_wr && (paddr == sme_pkg::OFS_ACC)) begin
      acc <= pwdata[sme_pkg::DATA_W-1:0];
    end else if (sw_wr && (paddr == sme_pkg::OFS_STATUS)) begin
      carry <= pwdata[sme_pkg::ST_CARRY];
      zero <= pwdata[sme_pkg::ST_ZERO];
      unk <= pwdata[sme_pkg::ST_UNK];
    end else if (sw_wr && is_instr) begin
      unk <= (dec_op == sme_pkg::SME_OP_BAD);
      if (dec_op == sme_pkg::SME_OP_ACC) begin
        acc <= iw[7:0];
      end
    end else if (exec_fire) begin
      case (op_q)
        sme_pkg::SME_OP_SHIFT: begin
          carry <= dfile.rdata[0];
          zero <= (shift_res == '0);
          if (!dest_q) begin
            acc <= shift_res;
          end
        end
        sme_pkg::SME_OP_COPY: begin
          zero <= (dfile.rdata == '0);
          if (!dest_q) begin
            acc <= dfile.rdata;
          end
        end
        sme_pkg::SME_OP_IND: begin
          acc <= dfile.rdata;
          zero <= (dfile.rdata == '0);
        end
        default: begin
          acc <= acc;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bank select and page latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select <= '0;
      program_counter_high_latch <= '0;
    end else if (sw_wr && (paddr == sme_pkg::OFS_BANK)) begin
      bank_select <= pwdata[sme_pkg::BANK_W-1:0];
    end else if (sw_wr && (paddr == sme_pkg::OFS_PAGE)) begin
      program_counter_high_latch <= pwdata[sme_pkg::PAGE_W-1:0];
    end else if (sw_wr && is_instr && (dec_op == sme_pkg::SME_OP_BANK)) begin
      bank_select <= iw[sme_pkg::BANK_W-1:0];
    end else if (sw_wr && is_instr && (dec_op == sme_pkg::SME_OP_PAGE)) begin
      program_counter_high_latch <= iw[sme_pkg::PAGE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Indirect pointers, one process per pointer
  // ----------------------------------------------------------------
  // The step is applied at issue; the read address was fixed already
  for (genvar g = 0; g < 2; g++) begin : g_ptr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        indirect_pointer[g] <= sme_pkg::RST_PTR;
      end else if (sw_wr && (paddr == sme_pkg::OFS_PTR[g])) begin
        indirect_pointer[g] <= pwdata[sme_pkg::PTR_W-1:0];
      end else if (sw_wr && is_instr && (dec_op == sme_pkg::SME_OP_IND) && (dec_sel == g)) begin
        indirect_pointer[g] <= dec_ptr_next;
      end
    end
  end

  // Software data address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_addr <= '0;
    end else if (sw_wr && (paddr == sme_pkg::OFS_DADDR)) begin
      sw_addr <= pwdata[sme_pkg::PTR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      sme_pkg::OFS_ACC: begin
        rd_mux = {24'h00_0000, acc};
      end
      sme_pkg::OFS_STATUS: begin
        rd_mux = {29'h0000_0000, unk, zero, carry};
      end
      sme_pkg::OFS_BANK: begin
        rd_mux = {27'h000_0000, bank_select};
      end
      sme_pkg::OFS_PAGE: begin
        rd_mux = {25'h000_0000, program_counter_high_latch};
      end
      sme_pkg::OFS_PTR[0]: begin
        rd_mux = {16'h0000, indirect_pointer[0]};
      end
      sme_pkg::OFS_PTR[1]: begin
        rd_mux = {16'h0000, indirect_pointer[1]};
      end
      sme_pkg::OFS_DADDR: begin
        rd_mux = {16'h0000, sw_addr};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // pready is raised for exactly the cycle spent in the response state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= (next_state == sme_pkg::SME_RESP);
      if (acc_start) begin
        pslverr <= !hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (exec_fire && (op_q == sme_pkg::SME_OP_SWRD)) begin
        prdata <= {24'h00_0000, dfile.rdata};
      end else if (state == sme_pkg::SME_RESP) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: test/sme_exec_asserts.sv
// Port checker for the shift/move executor, APB side only.
// Assumes the top-level port names of sme_exec.
`timescale 1ns/1ps
`default_nettype none
module sme_exec_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sme_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ---
  // Handshake timing
  // ---
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_reg_one_wait: assert property ($rose(penable) && psel && paddr inside {[12'h004:12'h01c]} |=> pready)
    else $error("register access late");
  chk_shift_three_waits: assert property ($rose(penable) && psel && pwrite && paddr == 12'h000
    && pwdata[13:8] == 6'h0d |=> !pready ##1 !pready ##1 pready) else $error("shift answer timing");
  chk_data_read_waits: assert property ($rose(penable) && psel && !pwrite && paddr == 12'h020
    |=> !pready[*2] ##1 pready) else $error("data read timing");
  // Refusals: unmapped gives an error, nothing else does
  chk_unmapped_error: assert property ($rose(penable) && psel && paddr > 12'h020 |=> pready && pslverr)
    else $error("unmapped not refused");
  chk_mapped_no_error: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("spurious error");
  chk_instr_read_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
    else $error("instruction read not zero");
  chk_error_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error with data");
endmodule
bind sme_exec sme_exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: test/sme_prog_src.sv
// Program memory stand-in: a fixed table of instruction words.
// Assumes the bench picks a slot and lets an edge pass before use.
`timescale 1ns/1ps
`default_nettype none
module sme_prog_src (
  input wire logic [2:0] idx,
  output logic [13:0] word
);
  // Slot table; the bank and page literal slots hold their top values
  always_comb begin
    case (idx)
      3'h0: word = 14'h0d20; // Shift into accumulator
      3'h1: word = 14'h0da0; // Shift back into file
      3'h2: word = 14'h08a0; // Copy onto itself
      3'h3: word = 14'h0800; // Copy through window 0
      3'h4: word = 14'h30a5; // Accumulator literal
      3'h5: word = 14'h003f; // Bank literal, top value
      3'h6: word = 14'h31ff; // Page literal, top value
      default: word = 14'h0000; // Decodes as nothing
    endcase
  end
endmodule
`default_nettype wire

// File: test/shift_move_instr_exec_tb_top.sv
// Self-checking bench: APB master, read notes queued, checked by a monitor.
// Assumes sme_exec at its default file size of 512 bytes.
`timescale 1ns/1ps
`default_nettype none
module shift_move_instr_exec_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rng = 32'h0000000e;
  logic pready, pslverr, c, z;
  logic [32:0] expq[$]; // Expected {error, data} per read
  int error_cnt = 0, n_tests = 0;
  logic [2:0] idx = 3'h0;
  logic [13:0] word;
  logic [7:0] v, d, m[3];
  logic [15:0] p;
  sme_exec DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sme_prog_src u_src (.idx(idx), .word(word));
  initial begin
    forever #2 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; bounded wait on pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic run(input logic [2:0] i);
    idx = i;
    @(posedge pclk);
    xfer(1'b1, 12'h000, {18'h0, word});
  endtask
  task automatic poke(input logic [15:0] a, input logic [7:0] dt);
    xfer(1'b1, 12'h01c, {16'h0, a});
    xfer(1'b1, 12'h020, {24'h0, dt});
  endtask
  // Monitor: every completed read is compared with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      check({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 33'h0);
    rd(12'h024, 33'h100000000);
    rd(12'h000, 33'h0);
    repeat (4) begin
      rng = xs(rng);
      v = rng[7:0];
      poke(16'h0020, v);
      run(3'h0);
      c = v[0];
      z = (v >> 1) == 8'h00;
      rd(12'h004, {26'h0, v[7:1]});
      rd(12'h008, {31'h0, z, c});
      run(3'h1);
      rd(12'h020, {26'h0, v[7:1]});
      poke(16'h0020, 8'h00);
      run(3'h2);
      rd(12'h008, {31'h0, 1'b1, c});
      poke(16'h0020, v);
      run(3'h2);
      rd(12'h008, {31'h0, v == 8'h00, c});
    end
    run(3'h4);
    rd(12'h004, 33'h0a5);
    run(3'h7);
    rd(12'h008, {31'h1, v == 8'h00, c});
    run(3'h5);
    rd(12'h00c, 33'h01f);
    run(3'h6);
    rd(12'h00c, 33'h01f);
    rd(12'h010, 33'h07f);
    rd(12'h008, {31'h0, v == 8'h00, c});
    xfer(1'b1, 12'h00c, 32'h0);
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      p = k[1:0] == 2'h0 ? 16'hffff : (k[1:0] == 2'h1 ? 16'h0000 : rng[15:0]);
      for (int j = 0; j < 3; j++) begin
        m[j] = rng[8 * j + 8 +: 8];
        poke(p + 16'(j) - 16'h1, m[j]);
      end
      xfer(1'b1, k[2] ? 12'h018 : 12'h014, {16'h0, p});
      xfer(1'b1, 12'h000, {25'h000007e, k[2], 6'h3f});
      rd(12'h004, {25'h0, m[0]});
      xfer(1'b1, 12'h000, {28'h0000001, 1'b0, k[2], k[1:0]});
      d = k[1:0] == 2'h0 ? m[2] : (k[1:0] == 2'h1 ? m[0] : m[1]);
      rd(12'h004, {25'h0, d});
      rd(12'h008, {31'h0, d == 8'h00, c});
      p = k[0] ? p - 16'h1 : p + 16'h1;
      rd(k[2] ? 12'h018 : 12'h014, {17'h0, p});
      if (!k[2]) begin
        run(3'h3);
        rd(12'h004, {25'h0, k[0] ? m[0] : m[2]});
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
